// >>> pkg/ssb_defs.svh
`ifndef SSB_DEFS_SVH
`define SSB_DEFS_SVH

// ==========================================================
// Object indices
`define SSB_IDX_STATUS 16'h200d
`define SSB_IDX_CURR_READ 16'h2101
`define SSB_IDX_VOLT_READ 16'h2102
`define SSB_IDX_CURR_TGT_WR 16'h2201
`define SSB_IDX_CURR_TGT_RD 16'h2202
`define SSB_IDX_VOLT_TGT_WR 16'h2203
`define SSB_IDX_VOLT_TGT_RD 16'h2204

// ==========================================================
// Sub-indices of the status object
`define SSB_SUB_WORD0 8'h00
`define SSB_SUB_WORD1 8'h01

// ==========================================================
// Reset values
`define SSB_TARGET_RESET 32'h0000_0000
`define SSB_WORD_ZERO 32'h0000_0000

// ==========================================================
// First status word bit positions
`define SSB_W0_STANDBY 0
`define SSB_W0_ACTIVE 1
`define SSB_W0_CURR_TRIP 4
`define SSB_W0_VOLT_TRIP 5
`define SSB_W0_PWR_TRIP 6
`define SSB_W0_SENSE_OOB 7
`define SSB_W0_LOW_VOLT_TRIP 8
`define SSB_W0_SHUTDOWN 9
`define SSB_W0_LIN_PWR 10
`define SSB_W0_RES_PWR 11
`define SSB_W0_START_FAIL 12
`define SSB_W0_START_WAIT 13
`define SSB_W0_PHASE_CURR 14
`define SSB_W0_COMM 15
`define SSB_W0_TERM_CURR 16
`define SSB_W0_TERM_VOLT 17
`define SSB_W0_LIN_HEAT 18
`define SSB_W0_AUX_FUSE 19
`define SSB_W0_INTERLOCK 20
`define SSB_W0_MAINT 22
`define SSB_W0_DIODE_HEAT 23
`define SSB_W0_CONFIG 24
`define SSB_W0_STACK 25
`define SSB_W0_LINE_FAULT 26
`define SSB_W0_RES_HEAT 27
`define SSB_W0_UNDER_MIN 28
`define SSB_W0_REG_LOST 29
`define SSB_W0_UPDATE 30

// ==========================================================
// Second status word bit positions
`define SSB_W1_PHASE_MISS 0
`define SSB_W1_INPUT_FUSE 1
`define SSB_W1_FAN_STALL 2
`define SSB_W1_PWR_HEAT 4
`define SSB_W1_FILTER_HEAT 5
`define SSB_W1_CAP_HEAT 6
`define SSB_W1_XFMR_HEAT 7
`define SSB_W1_BAD_RATING 16
`define SSB_W1_FW_MISMATCH 17

`endif

// >>> pkg/ssb_pkg.sv
package ssb_pkg;

  // ==========================================================
  // Regulation mode, one-hot
  typedef enum logic [1:0] {
    SSB_MODE_CC = 2'h1,
    SSB_MODE_CV = 2'h2
  } ssb_mode_type;

  // ==========================================================
  // Whole state of the bank
  typedef struct packed {
    logic [31:0] currentTarget;
    logic [31:0] voltageTarget;
    logic [31:0] readData;
    logic readValid;
    logic accessDone;
    logic accessError;
    logic [31:0] regulationTarget;
  } ssb_state_type;

endpackage

// >>> rtl/ssb_status_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssb_defs.svh"

// Function
// - Status word read-only, live, never latched
// - Reading never clears any status bit
// - Word0 bit0 standby, bit1 output active
// - Word0 bits 4-8 trips and sense bounds
// - Word0 bits 9-11 shutdown, power limits
// - Word0 bits 12-15 boot, phase, comms
// - Word0 bits 16-20 ratings, heat, fuse, interlock
// - Word0 bits 22-30 further fault flags
// - Word1 bits 0-2 phase, fuse, fan
// - Word1 heat bits 4-7, bits 16-17
// - Questionable subset keeps fixed positions
// - Current reading read-only float average
// - Voltage reading follows sense when engaged
// - Current target RW, used in CC
// - Voltage target RW, used in CV
module ssb_status_bank (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [15:0] objIndex,
  input wire logic [7:0] objSubIndex,
  input wire logic objRead,
  input wire logic objWrite,
  input wire logic [31:0] objWriteData,
  output logic [31:0] objReadData,
  output logic objReadValid,
  output logic objDone,
  output logic objError,
  input wire logic outputStandby,
  input wire logic outputActive,
  input wire logic currentTripFlag,
  input wire logic voltageTripFlag,
  input wire logic powerTripFlag,
  input wire logic senseOutOfBoundsFlag,
  input wire logic lowVoltageTripFlag,
  input wire logic shutdownFlag,
  input wire logic linearModulePowerFlag,
  input wire logic resistorPowerFlag,
  input wire logic targetStartFailFlag,
  input wire logic targetStartWaitFlag,
  input wire logic phaseCurrentFlag,
  input wire logic commCorruptFlag,
  input wire logic terminalCurrentRatingFlag,
  input wire logic terminalVoltageRatingFlag,
  input wire logic linearModuleHeatFlag,
  input wire logic auxFuseFlag,
  input wire logic interlockOpenFlag,
  input wire logic maintenanceFlag,
  input wire logic diodeModuleHeatFlag,
  input wire logic configMismatchFlag,
  input wire logic firmwareStackFlag,
  input wire logic inputLineFaultFlag,
  input wire logic resistorModuleHeatFlag,
  input wire logic underMinRatingFlag,
  input wire logic regulationLostFlag,
  input wire logic targetUpdateFlag,
  input wire logic missingPhaseFlag,
  input wire logic inputFuseFlag,
  input wire logic fanStallFlag,
  input wire logic powerStageHeatFlag,
  input wire logic outputFilterHeatFlag,
  input wire logic outputCapacitorHeatFlag,
  input wire logic transformerHeatFlag,
  input wire logic badRatingFlag,
  input wire logic firmwareMismatchFlag,
  input wire logic [31:0] terminalCurrentAvg,
  input wire logic [31:0] terminalVoltageAvg,
  input wire logic [31:0] senseVoltageAvg,
  input wire logic senseEngaged,
  input wire ssb_pkg::ssb_mode_type regulationMode,
  output logic [31:0] currentTargetValue,
  output logic [31:0] voltageTargetValue,
  output logic [31:0] regulationTarget
);

  // ==========================================================
  // Helpers

  // Sets one bit of a word
  function automatic logic [31:0] setBit(input logic [31:0] word,
                                         input int pos,
                                         input logic value);
    logic [31:0] result;
    result = word;
    result[pos] = value;
    return result;
  endfunction

  // ==========================================================
  // Live status words

  // Assembled words and the chosen voltage source
  logic [31:0] statusWord0;
  logic [31:0] statusWord1;
  logic [31:0] voltageReading;

  // Word0 assembled from live flags, spare bits stay zero
  always_comb begin
    statusWord0 = `SSB_WORD_ZERO;
    // Output state
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_STANDBY,
                         outputStandby);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_ACTIVE,
                         outputActive);

    // Trips and sense bounds
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_CURR_TRIP,
                         currentTripFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_VOLT_TRIP,
                         voltageTripFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_PWR_TRIP,
                         powerTripFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_SENSE_OOB,
                         senseOutOfBoundsFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_LOW_VOLT_TRIP,
                         lowVoltageTripFlag);

    // Shutdown and power limits
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_SHUTDOWN,
                         shutdownFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_LIN_PWR,
                         linearModulePowerFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_RES_PWR,
                         resistorPowerFlag);

    // Boot, phase current and link
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_START_FAIL,
                         targetStartFailFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_START_WAIT,
                         targetStartWaitFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_PHASE_CURR,
                         phaseCurrentFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_COMM,
                         commCorruptFlag);

    // Ratings, heat, fuse and interlock
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_TERM_CURR,
                         terminalCurrentRatingFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_TERM_VOLT,
                         terminalVoltageRatingFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_LIN_HEAT,
                         linearModuleHeatFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_AUX_FUSE,
                         auxFuseFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_INTERLOCK,
                         interlockOpenFlag);

    // Further faults, bit 21 stays spare
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_MAINT,
                         maintenanceFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_DIODE_HEAT,
                         diodeModuleHeatFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_CONFIG,
                         configMismatchFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_STACK,
                         firmwareStackFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_LINE_FAULT,
                         inputLineFaultFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_RES_HEAT,
                         resistorModuleHeatFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_UNDER_MIN,
                         underMinRatingFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_REG_LOST,
                         regulationLostFlag);
    statusWord0 = setBit(statusWord0,
                         `SSB_W0_UPDATE,
                         targetUpdateFlag);
  end

  // Word1 assembled from live flags, spare bits stay zero
  always_comb begin
    statusWord1 = `SSB_WORD_ZERO;
    // Phase, input fuse and fan
    statusWord1 = setBit(statusWord1,
                         `SSB_W1_PHASE_MISS,
                         missingPhaseFlag);
    statusWord1 = setBit(statusWord1,
                         `SSB_W1_INPUT_FUSE,
                         inputFuseFlag);
    statusWord1 = setBit(statusWord1,
                         `SSB_W1_FAN_STALL,
                         fanStallFlag);

    // Heat faults, rating and firmware
    statusWord1 = setBit(statusWord1,
                         `SSB_W1_PWR_HEAT,
                         powerStageHeatFlag);
    statusWord1 = setBit(statusWord1,
                         `SSB_W1_FILTER_HEAT,
                         outputFilterHeatFlag);
    statusWord1 = setBit(statusWord1,
                         `SSB_W1_CAP_HEAT,
                         outputCapacitorHeatFlag);
    statusWord1 = setBit(statusWord1,
                         `SSB_W1_XFMR_HEAT,
                         transformerHeatFlag);
    statusWord1 = setBit(statusWord1,
                         `SSB_W1_BAD_RATING,
                         badRatingFlag);
    statusWord1 = setBit(statusWord1,
                         `SSB_W1_FW_MISMATCH,
                         firmwareMismatchFlag);
  end

  // Voltage source follows the sense terminals when engaged
  assign voltageReading = senseEngaged ? senseVoltageAvg
                                       : terminalVoltageAvg;

  // ==========================================================
  // State update

  // Whole bank state and its next value
  ssb_pkg::ssb_state_type state;
  ssb_pkg::ssb_state_type next_state;

  // Object access decode and target selection
  always_comb begin
    next_state = state;
    next_state.readValid = 1'b0;
    next_state.accessDone = 1'b0;
    next_state.accessError = 1'b0;
    // A write wins over a read in the same cycle
    if (objWrite) begin
      next_state.accessDone = 1'b1;
      // Only the two targets accept data; status is untouched
      unique case (objIndex)
        `SSB_IDX_CURR_TGT_WR: begin
          next_state.currentTarget = objWriteData;
        end
        `SSB_IDX_VOLT_TGT_WR: begin
          next_state.voltageTarget = objWriteData;
        end
        default: begin
          next_state.accessError = 1'b1;
        end
      endcase
    end else if (objRead) begin
      next_state.accessDone = 1'b1;
      next_state.readValid = 1'b1;
      next_state.readData = `SSB_WORD_ZERO;
      // Reads copy live values and change no status bit
      unique case (objIndex)
        `SSB_IDX_STATUS: begin
          if (objSubIndex == `SSB_SUB_WORD0) begin
            next_state.readData = statusWord0;
          end else if (objSubIndex == `SSB_SUB_WORD1) begin
            next_state.readData = statusWord1;
          end else begin
            next_state.readValid = 1'b0;
            next_state.accessError = 1'b1;
          end
        end
        `SSB_IDX_CURR_READ: begin
          next_state.readData = terminalCurrentAvg;
        end
        `SSB_IDX_VOLT_READ: begin
          next_state.readData = voltageReading;
        end
        `SSB_IDX_CURR_TGT_RD: begin
          next_state.readData = state.currentTarget;
        end
        `SSB_IDX_VOLT_TGT_RD: begin
          next_state.readData = state.voltageTarget;
        end
        default: begin
          next_state.readValid = 1'b0;
          next_state.accessError = 1'b1;
        end
      endcase
    end
    // Regulation target picked by the active mode
    // Codes other than CV fall back to the current target
    if (regulationMode == ssb_pkg::SSB_MODE_CV) begin
      next_state.regulationTarget = next_state.voltageTarget;
    end else begin
      next_state.regulationTarget = next_state.currentTarget;
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      // Targets clear, no answer pending
      state.currentTarget <= `SSB_TARGET_RESET;
      state.voltageTarget <= `SSB_TARGET_RESET;
      state.readData <= `SSB_WORD_ZERO;
      state.readValid <= 1'b0;
      state.accessDone <= 1'b0;
      state.accessError <= 1'b0;
      state.regulationTarget <= `SSB_TARGET_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs

  // Answers to the host
  assign objReadData = state.readData;
  assign objReadValid = state.readValid;
  assign objDone = state.accessDone;
  assign objError = state.accessError;

  // Stored targets and the one in use
  assign currentTargetValue = state.currentTarget;
  assign voltageTargetValue = state.voltageTarget;
  assign regulationTarget = state.regulationTarget;

endmodule

`default_nettype wire

// >>> sim/ssb_bank_props.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Object port checks
module ssb_bank_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [15:0] objIndex,
  input wire logic [7:0] objSubIndex,
  input wire logic objRead,
  input wire logic objWrite,
  input wire logic [31:0] objWriteData,
  input wire logic [31:0] objReadData,
  input wire logic objReadValid,
  input wire logic objDone,
  input wire logic objError,
  input wire logic outputStandby,
  input wire logic outputActive,
  input wire logic [31:0] terminalVoltageAvg,
  input wire logic [31:0] senseVoltageAvg,
  input wire logic senseEngaged,
  input wire ssb_pkg::ssb_mode_type regulationMode,
  input wire logic [31:0] currentTargetValue,
  input wire logic [31:0] voltageTargetValue,
  input wire logic [31:0] regulationTarget
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Request and answer steps
  sequence sRead(idx);
    objRead && !objWrite && objIndex == idx;
  endsequence
  sequence sWrite(idx);
    objWrite && objIndex == idx;
  endsequence
  sequence sOk;
    objDone && !objError;
  endsequence
  // Answer timing
  a_answer_next: assert property ((objRead || objWrite) |=> objDone)
    else $error("request not answered");
  a_idle_quiet: assert property (!(objRead || objWrite) |=> !objDone)
    else $error("answer without request");
  // Reads and refused status writes leave targets alone
  a_read_keeps: assert property (objRead && !objWrite |=>
    $stable(currentTargetValue) && $stable(voltageTargetValue))
    else $error("read changed a target");
  a_status_locked: assert property (sWrite(16'h200d) |=>
    objError && $stable(currentTargetValue) && $stable(voltageTargetValue))
    else $error("status write not refused");
  // Target writes
  a_curr_write: assert property (sWrite(16'h2201) |=> sOk ##0
    currentTargetValue == $past(objWriteData))
    else $error("current target not stored");
  a_volt_write: assert property (sWrite(16'h2203) |=> sOk ##0
    voltageTargetValue == $past(objWriteData))
    else $error("voltage target not stored");
  // Voltage reading source
  a_sense_read: assert property (sRead(16'h2102) ##0 senseEngaged |=>
    objReadValid && objReadData == $past(senseVoltageAvg))
    else $error("sense voltage not returned");
  a_term_read: assert property (sRead(16'h2102) ##0 !senseEngaged |=>
    objReadValid && objReadData == $past(terminalVoltageAvg))
    else $error("terminal voltage not returned");
  // Output state bits
  a_run_bits: assert property (sRead(16'h200d) ##0 objSubIndex == 8'h00
    |=> objReadData[1:0] == {$past(outputActive), $past(outputStandby)})
    else $error("standby or active bit wrong");
  // Regulation target follows mode
  a_cv_target: assert property ($past(regulationMode) ==
    ssb_pkg::SSB_MODE_CV |-> regulationTarget == voltageTargetValue)
    else $error("CV target wrong");
  a_cc_target: assert property ($past(regulationMode) ==
    ssb_pkg::SSB_MODE_CC |-> regulationTarget == currentTargetValue)
    else $error("CC target wrong");
endmodule

bind ssb_status_bank ssb_bank_props u_props (
  .clock(clock), .rst_b(rst_b), .objIndex(objIndex),
  .objSubIndex(objSubIndex), .objRead(objRead), .objWrite(objWrite),
  .objWriteData(objWriteData), .objReadData(objReadData),
  .objReadValid(objReadValid), .objDone(objDone), .objError(objError),
  .outputStandby(outputStandby), .outputActive(outputActive),
  .terminalVoltageAvg(terminalVoltageAvg),
  .senseVoltageAvg(senseVoltageAvg), .senseEngaged(senseEngaged),
  .regulationMode(regulationMode), .currentTargetValue(currentTargetValue),
  .voltageTargetValue(voltageTargetValue),
  .regulationTarget(regulationTarget)
);
`default_nettype wire

// >>> sim/ssb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Network host on the object port
module ssb_host_model (
  input wire logic clock,
  output logic [15:0] objIndex,
  output logic [7:0] objSubIndex,
  output logic objRead,
  output logic objWrite,
  output logic [31:0] objWriteData
);
  // Quiet port at time zero
  initial begin
    objRead = 1'b0;
    objWrite = 1'b0;
    objIndex = 16'h0000;
    objSubIndex = 8'h00;
    objWriteData = 32'h0000_0000;
  end
  // One request per cycle; words taken whole, no bit layout assumed
  task automatic access(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] d);
    @(posedge clock);
    #1;
    objWrite = wr;
    objRead = !wr;
    objIndex = idx;
    objSubIndex = sub;
    objWriteData = d;
  endtask
  // Release, data inverted so nothing stale lingers
  task automatic release_port();
    @(posedge clock);
    #1;
    objRead = 1'b0;
    objWrite = 1'b0;
    objWriteData = ~objWriteData;
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ==========================================================
  // Signals and bookkeeping
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] objIndex;
  logic [7:0] objSubIndex;
  logic objRead, objWrite, objReadValid, objDone, objError;
  logic [31:0] objWriteData, objReadData;
  logic [31:0] w0 = 32'h0, w1 = 32'h0, curAvg = 32'h0, voltAvg = 32'h0;
  logic [31:0] senseAvg = 32'h0, cTgt = 32'h0, vTgt = 32'h0;
  logic senseEngaged = 1'b0;
  ssb_pkg::ssb_mode_type regulationMode = ssb_pkg::SSB_MODE_CC;
  logic [34:0] expQ[$];
  logic [34:0] e, got;
  int errors = 0;
  int checked = 0;
  int seed = 18323;

  // Clock
  always #4 clock = ~clock;

  ssb_host_model host (.clock(clock), .objIndex(objIndex),
    .objSubIndex(objSubIndex), .objRead(objRead), .objWrite(objWrite),
    .objWriteData(objWriteData));

  ssb_status_bank dut (
    .clock(clock), .rst_b(rst_b), .objIndex(objIndex),
    .objSubIndex(objSubIndex), .objRead(objRead), .objWrite(objWrite),
    .objWriteData(objWriteData), .objReadData(objReadData),
    .objReadValid(objReadValid), .objDone(objDone), .objError(objError),
    .outputStandby(w0[0]), .outputActive(w0[1]), .currentTripFlag(w0[4]),
    .voltageTripFlag(w0[5]), .powerTripFlag(w0[6]),
    .senseOutOfBoundsFlag(w0[7]), .lowVoltageTripFlag(w0[8]),
    .shutdownFlag(w0[9]), .linearModulePowerFlag(w0[10]),
    .resistorPowerFlag(w0[11]), .targetStartFailFlag(w0[12]),
    .targetStartWaitFlag(w0[13]), .phaseCurrentFlag(w0[14]),
    .commCorruptFlag(w0[15]), .terminalCurrentRatingFlag(w0[16]),
    .terminalVoltageRatingFlag(w0[17]), .linearModuleHeatFlag(w0[18]),
    .auxFuseFlag(w0[19]), .interlockOpenFlag(w0[20]),
    .maintenanceFlag(w0[22]), .diodeModuleHeatFlag(w0[23]),
    .configMismatchFlag(w0[24]), .firmwareStackFlag(w0[25]),
    .inputLineFaultFlag(w0[26]), .resistorModuleHeatFlag(w0[27]),
    .underMinRatingFlag(w0[28]), .regulationLostFlag(w0[29]),
    .targetUpdateFlag(w0[30]), .missingPhaseFlag(w1[0]),
    .inputFuseFlag(w1[1]), .fanStallFlag(w1[2]),
    .powerStageHeatFlag(w1[4]), .outputFilterHeatFlag(w1[5]),
    .outputCapacitorHeatFlag(w1[6]), .transformerHeatFlag(w1[7]),
    .badRatingFlag(w1[16]), .firmwareMismatchFlag(w1[17]),
    .terminalCurrentAvg(curAvg), .terminalVoltageAvg(voltAvg),
    .senseVoltageAvg(senseAvg), .senseEngaged(senseEngaged),
    .regulationMode(regulationMode), .currentTargetValue(),
    .voltageTargetValue(), .regulationTarget());

  // Drive a request, shuffle live inputs, note the answer expected
  task automatic step(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] d);
    logic [31:0] v;
    logic ok;
    host.access(wr, idx, sub, d);
    w0 = $random(seed);
    w1 = $random(seed);
    curAvg = $random(seed);
    voltAvg = $random(seed);
    senseAvg = $random(seed);
    v = $random(seed);
    senseEngaged = v[0];
    regulationMode = v[1] ? ssb_pkg::SSB_MODE_CV : ssb_pkg::SSB_MODE_CC;
    ok = 1'b1;
    v = 32'h0;
    if (wr) begin
      if (idx == 16'h2201) cTgt = d;
      else if (idx == 16'h2203) vTgt = d;
      else ok = 1'b0;
      expQ.push_back({2'b00, !ok, 32'h0});
    end else begin
      case (idx)
        16'h200d: if (sub == 8'h00) v = w0 & 32'h7fdf_fff3;
          else if (sub == 8'h01) v = w1 & 32'h0003_00f7;
          else ok = 1'b0;
        16'h2101: v = curAvg;
        16'h2102: v = senseEngaged ? senseAvg : voltAvg;
        16'h2202: v = cTgt;
        16'h2204: v = vTgt;
        default: ok = 1'b0;
      endcase
      expQ.push_back({1'b1, ok, !ok, v});
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Answer monitor, oldest note first
  always @(negedge clock) begin
    if (objDone === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : '1;
      got = {e[34], objReadValid, objError, e[34] ? objReadData : 32'h0};
      checked++;
      if (got !== e) begin
        errors++;
        $display("Error t=%0t exp=%h got=%h", $time, e, got);
      end
    end
  end

  // Main sequence
  initial begin
    logic [31:0] v;
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1'b1;
    step(1'b0, 16'h2202, 8'h00, 32'h0);
    step(1'b0, 16'h2204, 8'h00, 32'h0);
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      step(1'b0, 16'h200d, 8'h00, 32'h0);
      step(1'b0, 16'h200d, 8'h00, 32'h0);
      step(1'b0, 16'h200d, 8'h01, 32'h0);
      step(1'b0, 16'h2101, 8'h00, 32'h0);
      step(1'b0, 16'h2102, 8'h00, 32'h0);
      step(1'b1, 16'h2201, 8'h00, v);
      step(1'b1, 16'h2203, 8'h00, ~v);
      step(1'b0, 16'h2202, 8'h00, 32'h0);
      step(1'b0, 16'h2204, 8'h00, 32'h0);
      step(1'b1, 16'h200d, 8'h00, v);
      step(1'b1, 16'h2101, 8'h00, v);
      step(1'b1, 16'h2102, 8'h00, v);
      step(1'b0, 16'h200d, 8'h02, 32'h0);
      step(1'b0, 16'h2202, 8'h00, 32'h0);
    end
    host.release_port();
    repeat (3) @(posedge clock);
    if (expQ.size() != 0) begin
      errors++;
      $display("Error t=%0t exp=%h got=%h", $time, 32'h0, expQ.size());
    end
    end_sim();
  end

  // Watchdog
  initial begin
    #16000;
    errors++;
    $display("Error t=%0t exp=%h got=%h", $time, 32'h0, expQ.size());
    end_sim();
  end
endmodule
`default_nettype wire
